// *** rtl/temp_trip_compare_readout.sv ***
// Threshold registers, trip flags and the temperature value register.
// Assumes a byte-wide register port driven by a bus front end on
// core_clk, and conversion results from logic on the same clock.

`default_nettype none

module temp_trip_compare_readout (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        conv_valid,
    input  wire logic [12:0] conv_temp,
    input  wire logic [1:0]  hyst_sel,
    input  wire logic        xfer_start,
    input  wire logic [1:0]  reg_addr,
    input  wire logic        byte_wr,
    input  wire logic [7:0]  byte_wdata,
    input  wire logic        byte_rd,
    output logic [7:0]       byte_rdata,
    output logic             byte_rvalid
);

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] crit;
        logic [12:0] temp;
        logic [7:0]  hold;
        logic        phase;
        logic [15:0] snap;
        logic [7:0]  rdata;
        logic        rvalid;
    } main_s;

    main_s       st_reg;
    main_s       st_next;
    logic [2:0]  flags;
    logic [12:0] thresh [3];
    logic [15:0] rd_word;
    logic [15:0] wr_word;

    conv_if conv ();

    // ------------------------------------------------------------------
    // Conversion feed
    // ------------------------------------------------------------------
    assign conv.valid = conv_valid;
    assign conv.temp  = conv_temp;

    always_comb
    begin
        unique case (hyst_sel)
            trip_pkg::HYST_SEL_OFF: conv.hyst = trip_pkg::HYST_STEPS_0;
            trip_pkg::HYST_SEL_1P5: conv.hyst = trip_pkg::HYST_STEPS_1P5;
            trip_pkg::HYST_SEL_3:   conv.hyst = trip_pkg::HYST_STEPS_3;
            default:                conv.hyst = trip_pkg::HYST_STEPS_6;
        endcase
    end

    // ------------------------------------------------------------------
    // Trip flags
    // ------------------------------------------------------------------
    // Bits 1:0 are stored as zero, so comparing bits 12:0 directly
    // lines the 0.25 degree code up with the 0.0625 degree reading
    assign thresh[0] = st_reg.lower[12:0];
    assign thresh[1] = st_reg.upper[12:0];
    assign thresh[2] = st_reg.crit[12:0];

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_flag
            // Enum order matches the thresh index
            trip_flag #(
                .MODE (trip_pkg::cmp_mode_e'(i))
            ) u_flag (
                .core_clk  (core_clk),
                .reset     (reset),
                .conv      (conv),
                .threshold (thresh[i]),
                .flag      (flags[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register read and write
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (reg_addr)
            trip_pkg::ADDR_ALARM_UPPER: rd_word = st_reg.upper;
            trip_pkg::ADDR_ALARM_LOWER: rd_word = st_reg.lower;
            trip_pkg::ADDR_CRITICAL:    rd_word = st_reg.crit;
            default:
                // Flags in 15:13 and reading in 12:0; bit 11 is 128 deg
                rd_word = {flags[2], flags[1], flags[0],
                           st_reg.temp};
        endcase
    end

    // Only sign and ten-bit code survive a write
    assign wr_word = {st_reg.hold, byte_wdata}
                     & trip_pkg::THRESH_MASK;

    always_comb
    begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        if (conv_valid)
            st_next.temp = conv_temp;
        if (xfer_start)
            st_next.phase = 1'b0;
        else if (byte_wr)
        begin
            if (!st_reg.phase)
            begin
                st_next.hold  = byte_wdata;
                st_next.phase = 1'b1;
            end
            else
            begin
                // Commit whole word at once; no half-written bound
                st_next.phase = 1'b0;
                unique case (reg_addr)
                    trip_pkg::ADDR_ALARM_UPPER:
                        st_next.upper = wr_word;
                    trip_pkg::ADDR_ALARM_LOWER:
                        st_next.lower = wr_word;
                    trip_pkg::ADDR_CRITICAL:
                        st_next.crit  = wr_word;
                    default:
                        st_next.hold  = st_reg.hold;
                endcase
            end
        end
        else if (byte_rd)
        begin
            st_next.rvalid = 1'b1;
            st_next.phase  = !st_reg.phase;
            if (!st_reg.phase)
            begin
                // Snapshot keeps both bytes from one conversion
                st_next.snap  = rd_word;
                st_next.rdata = rd_word[15:8];
            end
            else
                st_next.rdata = st_reg.snap[7:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_reg       <= '0;
            st_reg.upper <= trip_pkg::THRESH_RESET;
            st_reg.lower <= trip_pkg::THRESH_RESET;
            st_reg.crit  <= trip_pkg::THRESH_RESET;
            st_reg.temp  <= trip_pkg::TEMP_RESET;
        end
        else
            st_reg <= st_next;
    end

    assign byte_rdata  = st_reg.rdata;
    assign byte_rvalid = st_reg.rvalid;

endmodule

`default_nettype wire

// *** common/trip_pkg.sv ***
// Constants and types for the temperature trip compare and readout block.
// Assumes one core clock; all users reference names as trip_pkg::name.
//
// Overview of operation
// - Hold alarm upper bound, compare temperature against it
// - Hold alarm lower bound, compare temperature against it
// - Hold critical limit, sign in bit 12
// - Threshold bits 1:0 always read zero
// - Reading is 13-bit twos complement, 0.0625 per step
// - Top magnitude bit weighs 128 degrees
// - Value register read upper byte then lower
// - Trip flags follow comparisons only, nothing else
// - Bit 13 set when below lower bound
// - Bit 14 set when above upper bound
// - Bit 15 set when at or above critical
// - Both window flags clear means inside window
// - Selected hysteresis applies when a flag deasserts
// - Threshold code in bits 11:2, sign bit 12

`default_nettype none

package trip_pkg;

    // ------------------------------------------------------------------
    // Register pointers
    // ------------------------------------------------------------------
    localparam logic [1:0] ADDR_ALARM_UPPER = 2'h0;
    localparam logic [1:0] ADDR_ALARM_LOWER = 2'h1;
    localparam logic [1:0] ADDR_CRITICAL    = 2'h2;
    localparam logic [1:0] ADDR_TEMP_VALUE  = 2'h3;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          TEMP_W          = 13;
    localparam int          HYST_W          = 7;
    localparam logic [15:0] THRESH_MASK     = 16'h1ffc;
    localparam int          BIT_BELOW       = 13;
    localparam int          BIT_ABOVE       = 14;
    localparam int          BIT_CRIT        = 15;
    localparam logic [15:0] THRESH_RESET    = 16'h0000;
    localparam logic [12:0] TEMP_RESET      = 13'h0000;

    // ------------------------------------------------------------------
    // Hysteresis in reading steps of 0.0625 degrees
    // ------------------------------------------------------------------
    localparam logic [1:0]  HYST_SEL_OFF    = 2'h0;
    localparam logic [1:0]  HYST_SEL_1P5    = 2'h1;
    localparam logic [1:0]  HYST_SEL_3      = 2'h2;
    localparam logic [6:0]  HYST_STEPS_0    = 7'h00;
    localparam logic [6:0]  HYST_STEPS_1P5  = 7'h18;
    localparam logic [6:0]  HYST_STEPS_3    = 7'h30;
    localparam logic [6:0]  HYST_STEPS_6    = 7'h60;

    typedef enum {
        CMP_BELOW,
        CMP_ABOVE,
        CMP_AT_OR_ABOVE
    } cmp_mode_e;

endpackage

`default_nettype wire

// *** common/conv_if.sv ***
// Carries each conversion result and the hysteresis step count.
// Assumes source and sinks share core_clk.

`default_nettype none

interface conv_if;
    logic        valid;
    logic [12:0] temp;
    logic [6:0]  hyst;

    modport source (output valid, output temp, output hyst);
    modport sink   (input  valid, input  temp, input  hyst);
endinterface

`default_nettype wire

// *** rtl/trip_flag.sv ***
// One trip flag: compares each conversion against a threshold.
// Assumes threshold and conversion data are on core_clk.

`default_nettype none

module trip_flag #(
    parameter trip_pkg::cmp_mode_e MODE = trip_pkg::CMP_ABOVE
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    conv_if.sink             conv,
    input  wire logic [12:0] threshold,
    output logic             flag
);

    typedef struct packed {
        logic flag;
    } flag_s;

    flag_s             st_reg;
    flag_s             st_next;
    logic signed [14:0] t;
    logic signed [14:0] th;
    logic signed [14:0] h;

    // ------------------------------------------------------------------
    // Compare with hysteresis on release
    // ------------------------------------------------------------------
    // Wide signed math so threshold plus band never wraps
    always_comb
    begin
        st_next = st_reg;
        t  = {{2{conv.temp[12]}}, conv.temp};
        th = {{2{threshold[12]}}, threshold};
        h  = {8'h00, conv.hyst};
        if (conv.valid)
        begin
            unique case (MODE)
                trip_pkg::CMP_BELOW:
                    if (t < th)
                        st_next.flag = 1'b1;
                    else if (t >= th + h)
                        st_next.flag = 1'b0;
                trip_pkg::CMP_ABOVE:
                    if (t > th)
                        st_next.flag = 1'b1;
                    else if (t <= th - h)
                        st_next.flag = 1'b0;
                trip_pkg::CMP_AT_OR_ABOVE:
                    if (t >= th)
                        st_next.flag = 1'b1;
                    else if (t < th - h)
                        st_next.flag = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign flag = st_reg.flag;

endmodule

`default_nettype wire

// *** tb/trip_host.sv ***
// Host model driving the byte register port of the trip block.
// Assumes core_clk of the block; changes signals at falling edges.
`default_nettype none
module trip_host (
    input  wire logic       core_clk,
    output logic            xfer_start,
    output logic [1:0]      reg_addr,
    output logic            byte_wr,
    output logic [7:0]      byte_wdata,
    output logic            byte_rd,
    input  wire logic [7:0] byte_rdata,
    input  wire logic       byte_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
        {xfer_start, reg_addr, byte_wr, byte_wdata, byte_rd} = '0;
    // Released data bus flips, so a stale byte cannot pass
    task automatic step(input logic s, input logic [1:0] a,
                        input logic w, input logic r, input logic [7:0] d);
        @(negedge core_clk);
        xfer_start = s;
        reg_addr   = a;
        byte_wr    = w;
        byte_rd    = r;
        byte_wdata = w ? d : ~byte_wdata;
    endtask
    // Bounds only change between conversions, so no flag moves mid-write
    task automatic wr16(input logic [1:0] a, input logic [15:0] d);
        step(1'b1, a, 1'b0, 1'b0, 8'h00);
        step(1'b0, a, 1'b1, 1'b0, d[15:8]);
        step(1'b0, a, 1'b1, 1'b0, d[7:0]);
        step(1'b0, a, 1'b0, 1'b0, 8'h00);
    endtask
    task automatic rd16(input logic [1:0] a, output logic [16:0] q);
        step(1'b1, a, 1'b0, 1'b0, 8'h00);
        step(1'b0, a, 1'b0, 1'b1, 8'h00);
        step(1'b0, a, 1'b0, 1'b1, 8'h00);
        q[16]   = byte_rvalid;
        q[15:8] = byte_rdata;
        step(1'b0, a, 1'b0, 1'b0, 8'h00);
        q[16]   = q[16] & byte_rvalid;
        q[7:0]  = byte_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb/trip_readout_sva.sv ***
// Checker on the register port of the trip block.
// Assumes reads come in upper/lower pairs after xfer_start.
`default_nettype none
module trip_readout_sva (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        conv_valid,
    input wire logic [12:0] conv_temp,
    input wire logic        xfer_start,
    input wire logic [1:0]  reg_addr,
    input wire logic        byte_wr,
    input wire logic        byte_rd,
    input wire logic [7:0]  byte_rdata,
    input wire logic        byte_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        low_reg;
    logic        was_low_reg;
    logic [1:0]  addr_reg;
    logic [12:0] temp_reg;
    logic [12:0] snap_reg;
    wire         take = (byte_rd | byte_wr) & ~xfer_start;
    always_ff @(posedge core_clk)
        low_reg <= (reset | xfer_start) ? 1'b0 : low_reg ^ take;
    always_ff @(posedge core_clk)
        temp_reg <= reset ? 13'h0000 : conv_valid ? conv_temp : temp_reg;
    // Snapshot mirrors the reading latched at the upper byte
    always_ff @(posedge core_clk)
    begin
        if (take & ~byte_wr)
        begin
            was_low_reg <= low_reg;
            addr_reg    <= reg_addr;
            snap_reg    <= low_reg ? snap_reg : temp_reg;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence rd_take; byte_rd & ~byte_wr & ~xfer_start; endsequence
    sequence thr_byte; byte_rvalid & (addr_reg != 2'h3); endsequence
    sequence val_byte; byte_rvalid & (addr_reg == 2'h3); endsequence
    rvalid_follows_a: assert property (rd_take |=> byte_rvalid)
        else $error("byte_rvalid missing after read");
    rvalid_only_a: assert property (!byte_rd | byte_wr | xfer_start
        |=> !byte_rvalid) else $error("byte_rvalid without read");
    rdata_hold_a: assert property (!byte_rvalid && !$past(reset)
        |-> $stable(byte_rdata)) else $error("byte_rdata moved");
    reset_clear_a: assert property ($past(reset)
        |-> byte_rdata == 8'h00 && !byte_rvalid) else $error("reset state");
    thr_low_zero_a: assert property (thr_byte and was_low_reg
        |-> byte_rdata[1:0] == 2'h0) else $error("threshold bits 1:0");
    thr_high_zero_a: assert property (thr_byte and !was_low_reg
        |-> byte_rdata[7:5] == 3'h0) else $error("threshold bits 15:13");
    temp_high_a: assert property (val_byte and !was_low_reg
        |-> byte_rdata[4:0] == snap_reg[12:8]) else $error("reading high");
    temp_low_a: assert property (val_byte and was_low_reg
        |-> byte_rdata == snap_reg[7:0]) else $error("reading low");
endmodule
bind temp_trip_compare_readout trip_readout_sva chk_u (.core_clk, .reset,
    .conv_valid, .conv_temp, .xfer_start, .reg_addr, .byte_wr, .byte_rd,
    .byte_rdata, .byte_rvalid);
`default_nettype wire

// *** tb/tb_temp_trip_compare_readout.sv ***
// Self-checking bench for the trip compare and readout block.
// Assumes trip_host drives the register port; bench drives conversions.
`default_nettype none
module tb_temp_trip_compare_readout;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk;
    logic        reset;
    logic        conv_valid;
    logic [12:0] conv_temp;
    logic [1:0]  hyst_sel;
    wire logic   xfer_start, byte_wr, byte_rd, byte_rvalid;
    wire logic [1:0] reg_addr;
    wire logic [7:0] byte_wdata, byte_rdata;
    int          bad_count;
    int          checks_done;
    trip_host host_u (.core_clk, .xfer_start, .reg_addr, .byte_wr,
        .byte_wdata, .byte_rd, .byte_rdata, .byte_rvalid);
    temp_trip_compare_readout dut_u (.core_clk, .reset, .conv_valid,
        .conv_temp, .hyst_sel, .xfer_start, .reg_addr, .byte_wr,
        .byte_wdata, .byte_rd, .byte_rdata, .byte_rvalid);
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic summarize;
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
        logic [16:0] q;
        host_u.rd16(a, q);
        checks_done++;
        if (q !== {1'b1, e})
        begin
            $display("[ERR] reg %0d expected %h seen %h", a, {1'b1, e}, q);
            bad_count++;
        end
    endtask
    task automatic conv(input logic [12:0] t);
        @(negedge core_clk);
        conv_valid = 1'b1;
        conv_temp  = t;
        @(negedge core_clk);
        conv_valid = 1'b0;
        conv_temp  = ~t;
    endtask
    task automatic reset_values;
        for (int a = 0; a < 4; a++)
            rd_chk(2'(a), 16'h0000);
    endtask
    task automatic thr_masking;
        for (int a = 0; a < 3; a++)
        begin
            host_u.wr16(2'(a), 16'hffff);
            rd_chk(2'(a), 16'h1ffc);
            host_u.wr16(2'(a), 16'he003);
            rd_chk(2'(a), 16'h0000);
        end
    endtask
    // Hysteresis off, so every flag is the exact comparison
    task automatic window_flags;
        logic [12:0] t [9] = '{13'h018f, 13'h0190, 13'h0320, 13'h0321,
            13'h04af, 13'h04b0, 13'h0fff, 13'h1fff, 13'h1000};
        host_u.wr16(2'h0, 16'h0320);
        host_u.wr16(2'h1, 16'h0190);
        host_u.wr16(2'h2, 16'h04b0);
        foreach (t[i])
        begin
            conv(t[i]);
            rd_chk(2'h3, {$signed(t[i]) >= $signed(13'h04b0),
                $signed(t[i]) > $signed(13'h0320),
                $signed(t[i]) < $signed(13'h0190), t[i]});
        end
    endtask
    // New bound waits for the next conversion
    task automatic ro_and_stale;
        host_u.wr16(2'h3, 16'hffff);
        rd_chk(2'h3, 16'h3000);
        host_u.wr16(2'h1, 16'h1000);
        rd_chk(2'h3, 16'h3000);
        conv(13'h1000);
        rd_chk(2'h3, 16'h1000);
    endtask
    task automatic hysteresis;
        hyst_sel = 2'h1;
        conv(13'h04b0);
        rd_chk(2'h3, 16'hc4b0);
        conv(13'h04af);
        rd_chk(2'h3, 16'hc4af);
        conv(13'h0497);
        rd_chk(2'h3, 16'h4497);
        conv(13'h0308);
        rd_chk(2'h3, 16'h0308);
    endtask
    // Wider bands, and the below flag's release
    task automatic hyst_wide;
        hyst_sel = 2'h2;
        host_u.wr16(2'h1, 16'h0190);
        conv(13'h018f);
        rd_chk(2'h3, 16'h218f);
        conv(13'h01bf);
        rd_chk(2'h3, 16'h21bf);
        conv(13'h01c0);
        rd_chk(2'h3, 16'h01c0);
        hyst_sel = 2'h3;
        conv(13'h0321);
        rd_chk(2'h3, 16'h4321);
        conv(13'h02c1);
        rd_chk(2'h3, 16'h42c1);
        conv(13'h02c0);
        rd_chk(2'h3, 16'h02c0);
    endtask
    // Reset in mid-run must clear bounds written earlier
    task automatic mid_reset;
        @(negedge core_clk);
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        reset_values();
    endtask
    initial
    begin
        reset       = 1'b1;
        conv_valid  = 1'b0;
        conv_temp   = 13'h0000;
        hyst_sel    = 2'h0;
        bad_count   = 0;
        checks_done = 0;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        reset_values();
        thr_masking();
        window_flags();
        ro_and_stale();
        hysteresis();
        hyst_wide();
        mid_reset();
        summarize();
    end
    initial
    begin
        #1000000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
